// ---- chg_smbus_regs.v ----
`include "chg_consts.vh"
`default_nettype none
module chg_smbus_regs #(
  parameter [15:0] MAKER_CODE = 16'h5A5A, // arbitrary
  parameter [15:0] PART_CODE  = 16'h0101, // arbitrary
  parameter [39:0] LIMIT_44   = `CHG_WDOG_44_S  * 40'd50000000,
  parameter [39:0] LIMIT_88   = `CHG_WDOG_88_S  * 40'd50000000,
  parameter [39:0] LIMIT_175  = `CHG_WDOG_175_S * 40'd50000000
) (
  input  wire       core_clk_i,
  input  wire       rst_n_i,
  input  wire       supply_ok_i,
  input  wire       adapter_detect_input_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  output reg        deglitch_short_o,
  output reg [1:0]  wdog_sel_o,
  output reg        freq_raise_o,
  output reg        freq_adj_en_o,
  output reg [1:0]  highside_short_compare_sel_o,
  output reg        current_monitor_output_sel_o,
  output reg        cmp_ref_high_o,
  output reg [1:0]  input_overcurrent_protect_sel_o,
  output reg        charge_enable_o,
  output reg [15:0] charge_current_o,
  output reg [15:0] charge_voltage_o,
  output reg [15:0] input_current_o
);
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_CMD  = 6'h04;
  localparam [5:0] ST_WR   = 6'h08;
  localparam [5:0] ST_RD   = 6'h10;
  localparam [5:0] ST_SKIP = 6'h20;

  reg  [15:0] opt_r;
  reg  [15:0] cur_r;
  reg  [15:0] volt_r;
  reg  [15:0] inp_r;
  reg  [5:0]  st_r;
  reg  [7:0]  cmd_r;
  reg  [7:0]  sh_r;
  reg  [3:0]  bit_r;
  reg         byte_r;
  reg  [7:0]  lo_r;
  reg  [15:0] rd_r;
  reg         scl_d_r;
  reg         sda_d_r;
  reg         ack_r;
  reg         kick_r;
  wire        expired;
  wire        bus_en   = supply_ok_i & adapter_detect_input_i;
  wire        scl_rise = scl_i & ~scl_d_r;
  wire        scl_fall = ~scl_i & scl_d_r;
  wire        start    = scl_i & scl_d_r & sda_d_r & ~sda_i;
  wire        stop     = scl_i & scl_d_r & ~sda_d_r & sda_i;
  wire [7:0]  sh_nxt   = {sh_r[6:0], sda_i};
  reg  [15:0] rd_sel;

  always @* begin
    case (cmd_r)
      `CHG_CMD_OPTIONS: rd_sel = opt_r;
      `CHG_CMD_CURRENT: rd_sel = cur_r;
      `CHG_CMD_VOLTAGE: rd_sel = volt_r;
      `CHG_CMD_INPUT:   rd_sel = inp_r;
      `CHG_CMD_MAKER:   rd_sel = MAKER_CODE;
      `CHG_CMD_PART:    rd_sel = PART_CODE;
      default:          rd_sel = 16'hFFFF;
    endcase
  end

  chg_wdog #(
    .LIMIT_44  (LIMIT_44),
    .LIMIT_88  (LIMIT_88),
    .LIMIT_175 (LIMIT_175)
  ) u_wdog (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n_i),
    .period_sel_i (opt_r[`CHG_OPT_WDOG_HI:`CHG_OPT_WDOG_LO]),
    .kick_i       (kick_r),
    .expired_o    (expired)
  );

  // byte engine: bit_r counts 0..7 data, 8 is the ack slot
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r    <= ST_IDLE;
      cmd_r   <= 8'h00;
      sh_r    <= 8'h00;
      bit_r   <= 4'h0;
      byte_r  <= 1'b0;
      lo_r    <= 8'h00;
      rd_r    <= 16'h0000;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      ack_r   <= 1'b0;
      kick_r  <= 1'b0;
      sda_o   <= 1'b0;
      sda_oe_o <= 1'b0;
      opt_r   <= `CHG_RST_OPTIONS;
      cur_r   <= `CHG_RST_CURRENT;
      volt_r  <= `CHG_RST_VOLTAGE;
      inp_r   <= `CHG_RST_INPUT;
    end else begin
      scl_d_r <= scl_i;
      sda_d_r <= sda_i;
      kick_r  <= 1'b0;
      sda_o   <= 1'b0;
      if (!bus_en || stop) begin
        st_r     <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start) begin
        st_r     <= ST_ADDR; // repeated start keeps cmd_r
        bit_r    <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (scl_rise && bit_r < 4'h8) begin
        sh_r  <= sh_nxt;
        bit_r <= bit_r + 4'h1;
        if (bit_r == 4'h7) begin
          ack_r <= 1'b0;
          case (st_r)
            ST_ADDR: begin
              if (sh_nxt[7:1] == `CHG_SLAVE_ADDR) begin
                ack_r  <= 1'b1;
                st_r   <= sh_nxt[0] ? ST_RD : ST_CMD;
                byte_r <= 1'b0;
                rd_r   <= rd_sel;
              end else begin
                st_r <= ST_SKIP;
              end
            end
            ST_CMD: begin
              cmd_r <= sh_nxt;
              ack_r <= 1'b1;
              st_r  <= ST_WR;
            end
            ST_WR: begin
              ack_r  <= 1'b1;
              byte_r <= ~byte_r;
              if (!byte_r) begin
                lo_r <= sh_nxt;
              end else begin
                case (cmd_r)
                  `CHG_CMD_OPTIONS: opt_r <= ({sh_nxt, lo_r} & `CHG_OPT_WMASK) |
                    (`CHG_RST_OPTIONS & ~`CHG_OPT_WMASK);
                  `CHG_CMD_CURRENT: begin
                    cur_r  <= {sh_nxt, lo_r} & `CHG_CUR_MASK;
                    kick_r <= 1'b1;
                  end
                  `CHG_CMD_VOLTAGE: begin
                    volt_r <= {sh_nxt, lo_r} & `CHG_VOLT_MASK;
                    kick_r <= 1'b1;
                  end
                  `CHG_CMD_INPUT:   inp_r <= {sh_nxt, lo_r} & `CHG_IN_MASK;
                  default: ;
                endcase
              end
            end
            default: ;
          endcase
        end
      end else if (scl_rise && bit_r == 4'h8) begin
        bit_r <= 4'h0;
        if (st_r == ST_RD) begin
          ack_r <= 1'b0;
          if (sda_i) begin
            st_r <= ST_SKIP; // master nack ends the read
          end else if (!ack_r) begin
            byte_r <= ~byte_r; // master ack: high byte follows
          end
        end
      end else if (scl_fall) begin
        // drive only while scl low so start/stop are never faked
        if (bit_r == 4'h8) begin
          sda_oe_o <= ack_r; // master-owned ack slots stay released
        end else if (st_r == ST_RD) begin
          sda_oe_o <= ~(byte_r ? rd_r[4'hF - bit_r[2:0]] : rd_r[4'h7 - bit_r[2:0]]);
        end else begin
          sda_oe_o <= 1'b0;
        end
        if (bit_r == 4'h0 && st_r != ST_RD) begin
          ack_r <= 1'b0;
        end
      end
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      deglitch_short_o                <= 1'b0;
      wdog_sel_o                      <= 2'b11;
      freq_raise_o                    <= 1'b0;
      freq_adj_en_o                   <= 1'b0;
      highside_short_compare_sel_o    <= 2'b10;
      current_monitor_output_sel_o    <= 1'b0;
      cmp_ref_high_o                  <= 1'b0;
      input_overcurrent_protect_sel_o <= 2'b10;
      charge_enable_o                 <= 1'b0;
      charge_current_o                <= 16'h0000;
      charge_voltage_o                <= 16'h0000;
      input_current_o                 <= 16'h0000;
    end else begin
      deglitch_short_o                <= opt_r[`CHG_OPT_DEGLITCH];
      wdog_sel_o                      <= opt_r[`CHG_OPT_WDOG_HI:`CHG_OPT_WDOG_LO];
      freq_raise_o                    <= opt_r[`CHG_OPT_FREQ_DIR];
      freq_adj_en_o                   <= opt_r[`CHG_OPT_FREQ_EN];
      highside_short_compare_sel_o    <= opt_r[`CHG_OPT_SHORT_HI:`CHG_OPT_SHORT_LO];
      current_monitor_output_sel_o    <= opt_r[`CHG_OPT_MON_SEL];
      cmp_ref_high_o                  <= opt_r[`CHG_OPT_CMP_REF];
      input_overcurrent_protect_sel_o <= opt_r[`CHG_OPT_OC_HI:`CHG_OPT_OC_LO];
      charge_enable_o <= ~opt_r[`CHG_OPT_INHIBIT] & ~expired;
      charge_current_o                <= cur_r;
      charge_voltage_o                <= volt_r;
      input_current_o                 <= inp_r;
    end
  end
endmodule
`default_nettype wire

// ---- chg_consts.vh ----
`ifndef CHG_CONSTS_VH
`define CHG_CONSTS_VH
`define CHG_SLAVE_ADDR      7'h09
`define CHG_CMD_OPTIONS     8'h12
`define CHG_CMD_CURRENT     8'h14
`define CHG_CMD_VOLTAGE     8'h15
`define CHG_CMD_INPUT       8'h3F
`define CHG_CMD_MAKER       8'hFE
`define CHG_CMD_PART        8'hFF
`define CHG_RST_OPTIONS     16'h7904
`define CHG_RST_CURRENT     16'h0000
`define CHG_RST_VOLTAGE     16'h0000
`define CHG_RST_INPUT       16'h1000
`define CHG_OPT_WMASK       16'hE7B7
`define CHG_CUR_MASK        16'h1FC0
`define CHG_VOLT_MASK       16'h7FF0
`define CHG_IN_MASK         16'h1F80
`define CHG_OPT_DEGLITCH    15
`define CHG_OPT_WDOG_HI     14
`define CHG_OPT_WDOG_LO     13
`define CHG_OPT_FREQ_DIR    10
`define CHG_OPT_FREQ_EN     9
`define CHG_OPT_SHORT_HI    8
`define CHG_OPT_SHORT_LO    7
`define CHG_OPT_MON_SEL     5
`define CHG_OPT_CMP_REF     4
`define CHG_OPT_OC_HI       2
`define CHG_OPT_OC_LO       1
`define CHG_OPT_INHIBIT     0
`define CHG_CLK_HZ          50000000
`define CHG_WDOG_44_S       44
`define CHG_WDOG_88_S       88
`define CHG_WDOG_175_S      175
`endif

// ---- chg_wdog.v ----
`default_nettype none
module chg_wdog #(
  parameter [39:0] LIMIT_44  = 40'd2200000000,
  parameter [39:0] LIMIT_88  = 40'd4400000000,
  parameter [39:0] LIMIT_175 = 40'd8750000000
) (
  input  wire       core_clk_i,
  input  wire       rst_n_i,
  input  wire [1:0] period_sel_i,
  input  wire       kick_i,
  output reg        expired_o
);
  reg  [39:0] cnt_r;
  reg  [39:0] limit;
  always @* begin
    case (period_sel_i)
      2'b01:   limit = LIMIT_44;
      2'b10:   limit = LIMIT_88;
      default: limit = LIMIT_175;
    endcase
  end
  // expiry holds until the next kick; disabling also releases it
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r     <= 40'h0;
      expired_o <= 1'b0;
    end else if (kick_i || period_sel_i == 2'b00) begin
      cnt_r     <= 40'h0;
      expired_o <= 1'b0;
    end else if (cnt_r >= limit - 40'h1) begin
      expired_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 40'h1;
    end
  end
endmodule
`default_nettype wire

// ---- chg_host_model.sv ----
`default_nettype none
module chg_host_model (
  input  wire logic core_clk_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // sda moves only with scl low; 4 clocks a phase keeps above the 3-clock minimum
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_low_o <= ~b;
    tick(3);
    scl_o <= 1'b1;
    tick(3);
    @(negedge core_clk_i) r = sda_i;
    @(posedge core_clk_i) scl_o <= 1'b0;
  endtask
  task automatic start_c;
    tick(1);
    sda_low_o <= 1'b0;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
  endtask
  task automatic stop_c;
    tick(1);
    sda_low_o <= 1'b1;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b0;
    tick(4);
  endtask
  task automatic put_byte(input logic [7:0] v, inout logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    nak = nak | r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, r);
  endtask
  task automatic wr_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                         output logic nak);
    nak = 1'b0;
    start_c();
    put_byte({a, 1'b0}, nak);
    put_byte(c, nak);
    put_byte(d[7:0], nak);
    put_byte(d[15:8], nak);
    stop_c();
  endtask
  task automatic rd_word(input logic [7:0] c, output logic [15:0] d, output logic nak);
    nak = 1'b0;
    start_c();
    put_byte({7'h09, 1'b0}, nak);
    put_byte(c, nak);
    start_c();
    put_byte({7'h09, 1'b1}, nak);
    get_byte(1'b0, d[7:0]);
    get_byte(1'b1, d[15:8]);
    stop_c();
  endtask
endmodule
`default_nettype wire

// ---- chg_regs_sva.sv ----
`include "chg_consts.vh"
`default_nettype none
module chg_regs_sva (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        supply_ok_i,
  input wire logic        adapter_detect_input_i,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic [1:0]  wdog_sel_o,
  input wire logic        charge_enable_o,
  input wire logic [15:0] charge_current_o,
  input wire logic [15:0] charge_voltage_o,
  input wire logic [15:0] input_current_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [49:0] set_w = {wdog_sel_o, charge_current_o, charge_voltage_o, input_current_o};
  sda_low_a: assert property (!sda_o) else $error("sda drive level not low");
  idle_release_a: assert property (!(supply_ok_i && adapter_detect_input_i) [*3] |->
    !sda_oe_o) else $error("sda pulled while bus disabled");
  oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda changed while scl high");
  set_on_rise_a: assert property ($changed(set_w) |-> $past(scl_i))
    else $error("setting changed outside scl high");
  cur_mask_a: assert property ((charge_current_o & ~`CHG_CUR_MASK) == 16'h0000)
    else $error("current unused bits set");
  volt_mask_a: assert property ((charge_voltage_o & ~`CHG_VOLT_MASK) == 16'h0000)
    else $error("voltage unused bits set");
  in_mask_a: assert property ((input_current_o & ~`CHG_IN_MASK) == 16'h0000)
    else $error("input unused bits set");
  reset_state_a: assert property ($rose(rst_n_i) |-> ##2 (wdog_sel_o == 2'h3 &&
    charge_enable_o && input_current_o == `CHG_RST_INPUT && charge_current_o == 16'h0000 &&
    charge_voltage_o == 16'h0000)) else $error("outputs wrong after reset");
  cover property ($fell(charge_enable_o));
  cover property ($rose(sda_oe_o));
  cover property ($changed(wdog_sel_o));
endmodule
bind chg_smbus_regs chg_regs_sva u_chg_regs_sva (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .supply_ok_i(supply_ok_i), .adapter_detect_input_i(adapter_detect_input_i), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wdog_sel_o(wdog_sel_o), .charge_enable_o(charge_enable_o),
  .charge_current_o(charge_current_o), .charge_voltage_o(charge_voltage_o),
  .input_current_o(input_current_o));
`default_nettype wire

// ---- tb.sv ----
`include "chg_consts.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        sup_r = 1'b1;
  logic        adp_r = 1'b1;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  wire         scl_w, low_w, oe_w, en_w, deg_w, fr_w, fe_w, mon_w, cmp_w;
  wire  [1:0]  wd_w, hs_w, oc_w;
  wire  [15:0] cur_w, vol_w, in_w;
  wire         sda_w = ~(low_w | oe_w);
  wire  [15:0] opt_obs = {deg_w, wd_w, 2'h3, fr_w, fe_w, hs_w, 1'b0, mon_w, cmp_w, 1'b0, oc_w, ~en_w};
  logic [7:0]  cmd_t [7] = '{8'h12, 8'h14, 8'h15, 8'h3F, 8'hFE, 8'hFF, 8'h20};
  logic [15:0] rst_t [7] = '{16'h7904, 16'h0000, 16'h0000, 16'h1000, 16'h5A5A, 16'h0101, 16'hFFFF};
  logic [15:0] wr_t [7] = '{16'hFFB7, 16'h1FC0, 16'h7FF0, 16'h1F80, 16'h5A5A, 16'h0101, 16'hFFFF};
  logic [15:0] opt_t [5] = '{16'hFFFF, 16'h0000, 16'h2082, 16'h4104, 16'h7904};
  chg_smbus_regs #(.LIMIT_44(40'd3000), .LIMIT_88(40'd6000), .LIMIT_175(40'd40000)) u_chg_smbus_regs (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .supply_ok_i(sup_r), .adapter_detect_input_i(adp_r),
    .scl_i(scl_w), .sda_i(sda_w), .sda_o(), .sda_oe_o(oe_w), .deglitch_short_o(deg_w),
    .wdog_sel_o(wd_w), .freq_raise_o(fr_w), .freq_adj_en_o(fe_w), .highside_short_compare_sel_o(hs_w),
    .current_monitor_output_sel_o(mon_w), .cmp_ref_high_o(cmp_w),
    .input_overcurrent_protect_sel_o(oc_w), .charge_enable_o(en_w), .charge_current_o(cur_w),
    .charge_voltage_o(vol_w), .input_current_o(in_w));
  chg_host_model u_chg_host_model (.core_clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl_w),
    .sda_low_o(low_w));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial forever #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    logic [15:0] d;
    logic        k;
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk("opt pins", `CHG_RST_OPTIONS, opt_obs);
    for (int i = 0; i < 7; i++) begin
      u_chg_host_model.rd_word(cmd_t[i], d, k);
      chk("reset value", rst_t[i], d);
      u_chg_host_model.wr_word(`CHG_SLAVE_ADDR, cmd_t[i], 16'hFFFF, k);
      chk("write ack", 16'h0000, {15'h0000, k});
      u_chg_host_model.rd_word(cmd_t[i], d, k);
      chk("readback", wr_t[i], d);
    end
    chk("cur pin", `CHG_CUR_MASK, cur_w);
    chk("volt pin", `CHG_VOLT_MASK, vol_w);
    chk("in pin", `CHG_IN_MASK, in_w);
    // kick first so a short watchdog period cannot disturb the option pins
    foreach (opt_t[i]) begin
      u_chg_host_model.wr_word(`CHG_SLAVE_ADDR, `CHG_CMD_CURRENT, 16'h0040, k);
      u_chg_host_model.wr_word(`CHG_SLAVE_ADDR, `CHG_CMD_OPTIONS, opt_t[i], k);
      u_chg_host_model.rd_word(`CHG_CMD_OPTIONS, d, k);
      chk("options", (opt_t[i] & `CHG_OPT_WMASK) | 16'h1800, d);
      chk("opt pins", (opt_t[i] & `CHG_OPT_WMASK) | 16'h1800, opt_obs);
    end
    u_chg_host_model.wr_word(`CHG_SLAVE_ADDR, `CHG_CMD_OPTIONS, 16'h3904, k);
    u_chg_host_model.wr_word(`CHG_SLAVE_ADDR, `CHG_CMD_CURRENT, 16'h0080, k);
    repeat (2500) @(posedge core_clk_i);
    chk("enable", 16'h0001, {15'h0000, en_w});
    repeat (1000) @(posedge core_clk_i);
    chk("enable", 16'h0000, {15'h0000, en_w});
    u_chg_host_model.wr_word(`CHG_SLAVE_ADDR, `CHG_CMD_VOLTAGE, 16'h1000, k);
    repeat (2) @(posedge core_clk_i);
    chk("enable", 16'h0001, {15'h0000, en_w});
    for (int i = 0; i < 3; i++) begin
      sup_r <= (i != 1);
      adp_r <= (i != 2);
      repeat (4) @(posedge core_clk_i);
      u_chg_host_model.wr_word(i == 0 ? 7'h0A : `CHG_SLAVE_ADDR, `CHG_CMD_CURRENT, 16'h1FC0, k);
      chk("refused nak", 16'h0001, {15'h0000, k});
      sup_r <= 1'b1;
      adp_r <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      chk("cur pin", 16'h0080, cur_w);
    end
    finish_test();
  end
endmodule
`default_nettype wire
